// *** design/fpet_consts.svh ***
// Timing constants of the flash program/erase sequencer.
// Assumes inclusion by the package and the sequencer; definitions only.
`ifndef FPET_CONSTS_SVH
`define FPET_CONSTS_SVH

// ----------------------------------------------------------------------
// Step lengths in timing generator periods
// ----------------------------------------------------------------------
`define FPET_T_WORD 14'h001E
`define FPET_T_BLK_FIRST 14'h0019
`define FPET_T_BLK_NEXT 14'h0012
`define FPET_T_BLK_END 14'h0006
`define FPET_T_MASS 14'h2961
`define FPET_T_SEG 14'h12D3
`define FPET_CNT_W 14
`define FPET_BLK_LAST 6'h3F
`define FPET_ONE_TICK 14'h0001

// ----------------------------------------------------------------------
// Timing generator divider
// ----------------------------------------------------------------------
`define FPET_DIV_W 8
`define FPET_DIV_ZERO 8'h00
`define FPET_SRC_W 2

`endif

// *** design/fpet_pkg.sv ***
// Types shared by the flash program/erase sequencer.
// Assumes the constants header is on the include path.
`include "fpet_consts.svh"

package fpet_pkg;

    // ------------------------------------------------------------------
    // Operation codes and request carrier
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FPET_OP_WORD,
        FPET_OP_BLOCK,
        FPET_OP_SEG,
        FPET_OP_MASS
    } fpet_op_t;

    typedef struct packed {
        fpet_op_t op;
        logic last;
    } fpet_req_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic prog_en;
        logic erase_en;
        logic item_done;
    } fpet_stat_t;

    typedef enum logic [2:0] {
        FPET_ST_IDLE,
        FPET_ST_WORD,
        FPET_ST_BLK,
        FPET_ST_WAIT,
        FPET_ST_END,
        FPET_ST_ERASE
    } fpet_state_t;

endpackage

// *** design/fpet_seq.sv ***
// Flash program/erase timing sequencer with its timing generator divider.
// Assumes a single core_clk domain; requests are synchronous pulses/levels.
//
// Overview of operation
// - A word or byte program lasts 30 timing generator periods.
// - First item of a block write lasts 25 timing generator periods.
// - Each further block item, positions one to 63, lasts 18 periods.
// - A block write ends with a 6 period end sequence.
// - Mass erase lasts 10593 timing generator periods.
// - Segment erase lasts 4819 timing generator periods.
// - All step lengths are fixed counts of timing generator periods.
`timescale 1ns/10ps
`include "fpet_consts.svh"

module fpet_seq (
    input wire logic core_clk, // System clock, 50 MHz.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic [`FPET_SRC_W-1:0] src_en, // Per-source enable pulses.
    input wire logic [`FPET_SRC_W-1:0] src_sel, // Selects the source enable.
    input wire logic [`FPET_DIV_W-1:0] div_ratio, // Divide by ratio plus one.
    input wire logic start, // One-cycle start request.
    input wire fpet_pkg::fpet_req_t req, // Operation and last-item flag.
    input wire logic data_valid, // Next block item is ready.
    output fpet_pkg::fpet_stat_t stat, // Busy, done and array strobes.
    output logic tick // Timing generator period pulse.
);

    // ------------------------------------------------------------------
    // Timing generator divider
    // ------------------------------------------------------------------
    logic [`FPET_DIV_W-1:0] div_q, div_d;
    logic tick_d, tick_q;
    logic src_pulse;

    always_comb begin
        // Only two sources exist, so the upper select bit is not decoded;
        // a full index would read past the enable vector.
        src_pulse = src_en[src_sel[0]];
        div_d = div_q;
        tick_d = 1'b0;
        if (src_pulse) begin
            if (div_q >= div_ratio) begin
                div_d = `FPET_DIV_ZERO;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 8'h01;
            end
        end
    end

    // Divider register; the ratio is sampled live, so software should
    // change it only while idle to keep step lengths exact.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_q <= `FPET_DIV_ZERO;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end
    assign tick = tick_q;

    // ------------------------------------------------------------------
    // Sequencer state machine
    // ------------------------------------------------------------------
    fpet_pkg::fpet_state_t st_q, st_d;
    logic [`FPET_CNT_W-1:0] cnt_q, cnt_d;
    logic last_q, last_d;
    logic done_q, done_d;
    logic item_q, item_d;
    logic [5:0] pos_q, pos_d;

    // Each step loads its length and counts ticks down to one.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        last_d = last_q;
        pos_d = pos_q;
        done_d = 1'b0;
        item_d = 1'b0;
        case (st_q)
            fpet_pkg::FPET_ST_IDLE: begin
                if (start) begin
                    last_d = req.last;
                    pos_d = 6'h00;
                    case (req.op)
                        fpet_pkg::FPET_OP_WORD: begin
                            st_d = fpet_pkg::FPET_ST_WORD;
                            cnt_d = `FPET_T_WORD;
                        end
                        fpet_pkg::FPET_OP_BLOCK: begin
                            st_d = fpet_pkg::FPET_ST_BLK;
                            cnt_d = `FPET_T_BLK_FIRST;
                        end
                        fpet_pkg::FPET_OP_SEG: begin
                            st_d = fpet_pkg::FPET_ST_ERASE;
                            cnt_d = `FPET_T_SEG;
                        end
                        fpet_pkg::FPET_OP_MASS: begin
                            st_d = fpet_pkg::FPET_ST_ERASE;
                            cnt_d = `FPET_T_MASS;
                        end
                        default: st_d = fpet_pkg::FPET_ST_IDLE;
                    endcase
                end
            end
            fpet_pkg::FPET_ST_WORD, fpet_pkg::FPET_ST_ERASE,
            fpet_pkg::FPET_ST_END: begin
                if (tick_q) begin
                    if (cnt_q == `FPET_ONE_TICK) begin
                        st_d = fpet_pkg::FPET_ST_IDLE;
                        done_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q - `FPET_ONE_TICK;
                    end
                end
            end
            fpet_pkg::FPET_ST_BLK: begin
                if (tick_q) begin
                    if (cnt_q == `FPET_ONE_TICK) begin
                        item_d = 1'b1;
                        if (last_q || pos_q == `FPET_BLK_LAST) begin
                            st_d = fpet_pkg::FPET_ST_END;
                            cnt_d = `FPET_T_BLK_END;
                        end else begin
                            st_d = fpet_pkg::FPET_ST_WAIT;
                        end
                    end else begin
                        cnt_d = cnt_q - `FPET_ONE_TICK;
                    end
                end
            end
            fpet_pkg::FPET_ST_WAIT: begin
                if (data_valid) begin
                    st_d = fpet_pkg::FPET_ST_BLK;
                    cnt_d = `FPET_T_BLK_NEXT;
                    pos_d = pos_q + 6'h01;
                    last_d = req.last;
                end
            end
            default: st_d = fpet_pkg::FPET_ST_IDLE;
        endcase
    end

    // State registers.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= fpet_pkg::FPET_ST_IDLE;
            cnt_q <= '0;
            last_q <= 1'b0;
            pos_q <= 6'h00;
            done_q <= 1'b0;
            item_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            last_q <= last_d;
            pos_q <= pos_d;
            done_q <= done_d;
            item_q <= item_d;
        end
    end

    assign stat.busy = (st_q != fpet_pkg::FPET_ST_IDLE);
    assign stat.done = done_q;
    assign stat.item_done = item_q;
    assign stat.erase_en = (st_q == fpet_pkg::FPET_ST_ERASE);
    assign stat.prog_en = (st_q == fpet_pkg::FPET_ST_WORD) ||
        (st_q == fpet_pkg::FPET_ST_BLK) || (st_q == fpet_pkg::FPET_ST_WAIT) ||
        (st_q == fpet_pkg::FPET_ST_END);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_word_start;
        start && !stat.busy && req.op == fpet_pkg::FPET_OP_WORD;
    endsequence

    a_word_loads: assert property (@(posedge core_clk) disable iff (reset)
        s_word_start |=> cnt_q == `FPET_T_WORD && st_q == fpet_pkg::FPET_ST_WORD)
        else $error("word program did not load 30 periods");
    a_blk_first: assert property (@(posedge core_clk) disable iff (reset)
        start && !stat.busy && req.op == fpet_pkg::FPET_OP_BLOCK |=> cnt_q == `FPET_T_BLK_FIRST)
        else $error("block first item not 25 periods");
    a_blk_next: assert property (@(posedge core_clk) disable iff (reset)
        st_q == fpet_pkg::FPET_ST_WAIT && data_valid |=> cnt_q == `FPET_T_BLK_NEXT)
        else $error("block next item not 18 periods");
    a_blk_end: assert property (@(posedge core_clk) disable iff (reset)
        st_q == fpet_pkg::FPET_ST_BLK && st_d == fpet_pkg::FPET_ST_END
        |=> st_q == fpet_pkg::FPET_ST_END && cnt_q == `FPET_T_BLK_END)
        else $error("block end sequence not 6 periods");
    a_mass_len: assert property (@(posedge core_clk) disable iff (reset)
        start && !stat.busy && req.op == fpet_pkg::FPET_OP_MASS |=> cnt_q == `FPET_T_MASS)
        else $error("mass erase not 10593 periods");
    a_seg_len: assert property (@(posedge core_clk) disable iff (reset)
        start && !stat.busy && req.op == fpet_pkg::FPET_OP_SEG |=> cnt_q == `FPET_T_SEG)
        else $error("segment erase not 4819 periods");
    a_count_tick: assert property (@(posedge core_clk) disable iff (reset)
        stat.busy && !tick_q && st_q != fpet_pkg::FPET_ST_WAIT |=> $stable(cnt_q))
        else $error("count moved without a tick");
    a_busy_hold: assert property (@(posedge core_clk) disable iff (reset)
        start && (st_q == fpet_pkg::FPET_ST_WORD || st_q == fpet_pkg::FPET_ST_ERASE ||
        st_q == fpet_pkg::FPET_ST_END)
        |=> (st_q == $past(st_q) || st_q == fpet_pkg::FPET_ST_IDLE) && cnt_q <= $past(cnt_q))
        else $error("start accepted while busy");
    a_div_tick: assert property (@(posedge core_clk) disable iff (reset)
        tick_q |-> $past(src_pulse))
        else $error("tick without source pulse");

endmodule

// *** dv/fpet_flash_model.sv ***
// Behavioural flash array side: hands over the next block item.
// Assumes core_clk, and that item_done is a one-cycle pulse.
`timescale 1ns/10ps

module fpet_flash_model (
    input wire logic core_clk, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic item_done, // Item programmed pulse.
    input wire logic more, // Further items remain.
    input wire logic [2:0] max_delay, // Longest stall in cycles.
    output logic data_valid // Next item ready, one cycle.
);
    int cnt;

    initial data_valid = 1'b0;

    // The stall is random so that prompt and slow answers both occur.
    always @(posedge core_clk) begin
        #1;
        data_valid <= !reset && !(item_done && more) && (cnt == 0);
        if (reset) begin
            cnt <= -1;
        end else if (item_done && more) begin
            cnt <= $urandom_range(max_delay, 0);
        end else if (cnt >= 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// *** dv/tb_flash_program_erase_timing.sv ***
// Self-checking bench of the program/erase sequencer.
// Assumes the package and the sequencer are compiled first.
`timescale 1ns/10ps

module tb_flash_program_erase_timing;
    logic core_clk, reset, start, data_valid, tick, waiting, more;
    logic [1:0] src_en, src_sel;
    logic [7:0] div_ratio;
    logic [2:0] max_delay;
    fpet_pkg::fpet_req_t req;
    fpet_pkg::fpet_stat_t stat;
    int errors, tests_run, tick_cnt, done_cnt, item_cnt, n_items, src_mode, win_ticks;
    int strobe_bad;
    logic is_erase;

    assign more = (item_cnt < n_items - 1);

    fpet_seq dut_u (.core_clk(core_clk), .reset(reset), .src_en(src_en), .src_sel(src_sel),
        .div_ratio(div_ratio), .start(start), .req(req), .data_valid(data_valid),
        .stat(stat), .tick(tick));

    fpet_flash_model flash_u (.core_clk(core_clk), .reset(reset), .item_done(stat.item_done),
        .more(more), .max_delay(max_delay), .data_valid(data_valid));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Source pulses: random, selected only, or unselected only.
    always @(posedge core_clk) begin
        #1;
        case (src_mode)
            0: src_en <= 2'($urandom);
            1: src_en <= 2'b01 << src_sel[0];
            default: src_en <= ~(2'b01 << src_sel[0]);
        endcase
        req.last <= !more;
    end

    // Ticks spent waiting for the array are not part of any step.
    always @(negedge core_clk) begin
        if (stat.busy === 1'b1 && tick === 1'b1) begin
            win_ticks++;
            if (!(waiting || (stat.item_done === 1'b1 && more))) tick_cnt++;
        end
        if (stat.done === 1'b1) done_cnt++;
        if (stat.item_done === 1'b1) begin
            if (more) waiting = 1'b1;
            item_cnt++;
        end
        if (data_valid === 1'b1) waiting = 1'b0;
        // Array strobes follow busy and the kind of operation.
        if ({stat.prog_en, stat.erase_en} !== (stat.busy ? {!is_erase, is_erase} : 2'b00))
            strobe_bad++;
    end

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Expected tick count of one operation, n items for a block.
    function automatic int model_ticks(input fpet_pkg::fpet_op_t op, input int n);
        case (op)
            fpet_pkg::FPET_OP_WORD: return 30;
            fpet_pkg::FPET_OP_BLOCK: return 25 + 18 * (n - 1) + 6;
            fpet_pkg::FPET_OP_SEG: return 4819;
            default: return 10593;
        endcase
    endfunction

    // Extra 1 pokes a refused start, extra 2 probes the divider mid-run.
    task automatic run_op(input fpet_pkg::fpet_op_t op, input int n, input int extra);
        int k;
        cycles(1);
        tick_cnt = 0; done_cnt = 0; item_cnt = 0; n_items = n; waiting = 1'b0;
        strobe_bad = 0;
        is_erase = (op == fpet_pkg::FPET_OP_SEG) || (op == fpet_pkg::FPET_OP_MASS);
        cycles(1);
        req.op = op;
        start = 1'b1;
        cycles(1);
        start = 1'b0;
        if (extra == 1) begin
            cycles(3);
            req.op = fpet_pkg::FPET_OP_MASS;
            start = 1'b1;
            cycles(1);
            start = 1'b0;
        end
        if (extra == 2) begin
            cycles(20);
            win_ticks = 0;
            cycles(12);
            check("ticks per window", win_ticks, 12 / (div_ratio + 1));
            src_mode = 2;
            cycles(3);
            win_ticks = 0;
            cycles(12);
            check("unselected ticks", win_ticks, 0);
            src_mode = 1;
        end
        k = 0;
        while (stat.done !== 1'b1 && k < 40000) begin
            cycles(1);
            k++;
        end
        if (k >= 40000) begin
            errors++;
            complete_run();
        end
        cycles(3);
        check("op ticks", tick_cnt, model_ticks(op, n));
        check("done pulses", done_cnt, 1);
        check("items", item_cnt, (op == fpet_pkg::FPET_OP_BLOCK) ? n : 0);
        check("busy after", 32'(stat.busy), 0);
        check("array strobes", strobe_bad, 0);
    endtask

    initial begin
        errors = 0; tests_run = 0; win_ticks = 0; n_items = 0; item_cnt = 0;
        strobe_bad = 0;
        is_erase = 1'b0;
        reset = 1'b1; start = 1'b0; src_en = 2'b00; src_sel = 2'b00;
        div_ratio = 8'h00; max_delay = 3'h0; src_mode = 0; waiting = 1'b0;
        req = '{op: fpet_pkg::FPET_OP_WORD, last: 1'b0};
        void'($urandom(32'h4c053e0c));
        cycles(20);
        reset = 1'b0;
        check("reset status", 32'({stat.busy, stat.done, tick}), 0);
        // tick rate window: a pulse every cycle divided by 106 to 194.
        src_mode = 1;
        div_ratio = 8'($urandom_range(193, 105));
        src_sel = 2'($urandom);
        max_delay = 3'h5;
        run_op(fpet_pkg::FPET_OP_WORD, 1, 0);
        run_op(fpet_pkg::FPET_OP_WORD, 1, 1);
        // Steps count ticks, so faster random ticks keep the long runs short.
        src_mode = 0;
        div_ratio = 8'($urandom_range(3, 0));
        run_op(fpet_pkg::FPET_OP_BLOCK, 1, 0);
        run_op(fpet_pkg::FPET_OP_BLOCK, 2, 0);
        max_delay = 3'h0;
        // total program time stays far below the per-block limit.
        run_op(fpet_pkg::FPET_OP_BLOCK, 64, 0);
        src_mode = 1;
        div_ratio = 8'h02;
        src_sel = 2'b01;
        run_op(fpet_pkg::FPET_OP_SEG, 1, 2);
        div_ratio = 8'h00;
        // one mass erase only; the array is never taken as erased.
        run_op(fpet_pkg::FPET_OP_MASS, 1, 0);
        complete_run();
    end
endmodule
